/* core/adc_channel_clock_trigger.sv */
// Converter control: AXI4-Lite registers, channel routing, clock choice,
// real-time counter trigger, conversion sequencing, compare and results.
// Assumes all inputs synchronous to clk and clock sources given as ticks.
//
// Added by the designer: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - codes 0-11 route the twelve pins
// - reserved codes convert, value undefined
// - code 11010 selects temperature sensor
// - bandgap code valid only with buffer
// - four selectable conversion clock sources
// - alternate clock keeps running in wait
// - no alternate clock in stop2/stop3
// - counter overflow starts one conversion
// - trigger ignores counter interrupt enable
// - trigger works in run, wait, stop3
// - counter clocks from three sources
// - right-justified 10-bit or 8-bit results
// - single or continuous, single returns idle
// - compare flags less-than or greater-equal
// - done flag with optional interrupt
// - all-ones channel powers converter off
// - status write aborts and restarts
module adc_channel_clock_trigger
	import adc_ctl_pkg::*;
(
	input  wire logic             clk,
	input  wire logic             rst,
	// AXI4-Lite slave
	input  wire logic [5:0]       awaddr,
	input  wire logic             awvalid,
	output logic                  awready,
	input  wire logic [31:0]      wdata,
	input  wire logic [3:0]       wstrb,
	input  wire logic             wvalid,
	output logic                  wready,
	output logic [1:0]            bresp,
	output logic                  bvalid,
	input  wire logic             bready,
	input  wire logic [5:0]       araddr,
	input  wire logic             arvalid,
	output logic                  arready,
	output logic [31:0]           rdata,
	output logic [1:0]            rresp,
	output logic                  rvalid,
	input  wire logic             rready,
	// Analog side, digitised
	input  wire logic [11:0][9:0] pinLevel,
	input  wire logic [9:0]       tempLevel,
	input  wire logic [9:0]       bandgapLevel,
	// Clock ticks and power modes
	input  wire logic             localAsyncConvClock,
	input  wire logic             extReferenceClock,
	input  wire logic             intReferenceClock,
	input  wire logic             lowPowerOscTick,
	input  wire logic             waitMode,
	input  wire logic             stop2Mode,
	input  wire logic             stop3Mode,
	// Status outputs
	output logic                  convIrq,
	output logic                  hwConversionTrigger,
	output logic [9:0]            convResult
);
	typedef enum logic {IDLE, CONVERT} conv_state_t;

	// Register state
	logic [4:0]  channelSelectField_q;
	logic        irqEnable_q, continuous_q, done_q;
	logic        hwTrigEnable_q, cmpEnable_q, cmpGreaterEq_q;
	logic [9:0]  compareVal_q;
	logic [7:0]  convCfg_q, cntCtrl_q, counterModuloReg_q;
	logic        bandgapBufferEnable_q;
	logic [9:0]  result_q;
	// Converter and counter state
	conv_state_t state_q, state_d;
	logic [5:0]  tick_q;
	logic [15:0] prescale_q;
	logic [7:0]  count_q;
	logic        ovf_q;
	// Bus state
	logic        bvalid_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;

	// Write path: address and data taken together, one at a time
	wire wrFire   = awvalid & wvalid & ~bvalid_q;
	wire wrLow    = wrFire & wstrb[0];
	wire wrHigh   = wrFire & wstrb[1];
	wire wrMapped = awaddr <= OFF_CNT_VALUE && awaddr[1:0] == 2'b00;
	wire wrSc     = wrLow & (awaddr == OFF_CONV_SC);
	wire wrCtrl   = wrLow & (awaddr == OFF_CONV_CTRL);
	wire wrCfg    = wrLow & (awaddr == OFF_CONV_CFG);
	wire wrCntCtl = wrLow & (awaddr == OFF_CNT_CTRL);
	wire wrCntMod = wrLow & (awaddr == OFF_CNT_MOD);
	wire wrPwr    = wrLow & (awaddr == OFF_PWR_CTRL);
	wire wrCmpLo  = wrLow & (awaddr == OFF_COMPARE);
	wire wrCmpHi  = wrHigh & (awaddr == OFF_COMPARE);
	assign awready = wrFire;
	assign wready  = wrFire;
	assign bvalid  = bvalid_q;
	assign bresp   = bresp_q;

	// Read path: one read outstanding, data registered
	wire rdFire     = arvalid & ~rvalid_q;
	wire rdMapped   = araddr <= OFF_CNT_VALUE && araddr[1:0] == 2'b00;
	wire rdResult   = rdFire & (araddr == OFF_RESULT);
	assign arready = rdFire;
	assign rvalid  = rvalid_q;
	assign rresp   = rresp_q;
	assign rdata   = rdata_q;

	// Configuration decode
	wire       longSample = convCfg_q[CF_LONG_BIT];
	wire       eightBit   = ~convCfg_q[CF_MODE_BIT];
	wire [1:0] clockDivideField = convCfg_q[CF_DIV_LSB +: 2];
	wire conv_src_t convSrc = conv_src_t'(convCfg_q[1:0]);
	wire cnt_src_t  cntSrc  = cnt_src_t'(cntCtrl_q[CC_SRC_LSB +: 2]);
	wire [3:0] counterPrescaleField = cntCtrl_q[3:0];
	wire       counterInterruptEnable = cntCtrl_q[CC_IRQEN_BIT];
	wire       stopLowPower = stop2Mode | stop3Mode;
	wire [5:0] convTicks  = longSample ? LONG_TICKS : SHORT_TICKS;

	// Routing and clock generation
	wire [9:0] convInput;
	wire       powerOff;
	wire       conversionClock;
	wire       busy = state_q == CONVERT;

	adc_chan_route u_route (
		.channelSelectField  (channelSelectField_q),
		.pinLevel            (pinLevel),
		.tempLevel           (tempLevel),
		.bandgapLevel        (bandgapLevel),
		.bandgapBufferEnable (bandgapBufferEnable_q),
		.convInput           (convInput),
		.powerOff            (powerOff)
	);

	adc_conv_clock u_clk (
		.clk                 (clk),
		.rst                 (rst),
		.clockSource         (convSrc),
		.clockDivideField    (clockDivideField),
		.localAsyncConvClock (localAsyncConvClock),
		.alternateConvClock  (extReferenceClock),
		.stopLowPower        (stopLowPower),
		.run                 (busy & ~stop2Mode),
		.conversionClock     (conversionClock)
	);

	// Counter clock select; prescale 0 holds the counter
	logic cntSrcTick;
	always_comb begin
		unique case (cntSrc)
			CSRC_EXT:  cntSrcTick = extReferenceClock;
			CSRC_INT:  cntSrcTick = intReferenceClock;
			CSRC_LPO:  cntSrcTick = lowPowerOscTick;
			CSRC_NONE: cntSrcTick = 1'b0;
		endcase
	end
	wire [15:0] prescaleMax = 16'((17'h1 << counterPrescaleField) - 17'h1);
	wire cntTick  = cntSrcTick & (counterPrescaleField != 4'h0) & (prescale_q == prescaleMax);
	// Stop2 powers the counter down, stop3 and wait keep it
	wire cntRun   = ~stop2Mode;
	wire overflow = cntRun & cntTick & (count_q == counterModuloReg_q);

	// Trigger ignores the counter interrupt enable entirely
	assign hwConversionTrigger = ovf_q;
	wire hwStart = ovf_q & hwTrigEnable_q & ~powerOff & ~busy;

	// Software start on a status write, unless the channel is off or the hardware trigger is enabled
	wire [4:0] newChan = wdata[4:0];
	wire swStart = wrSc & ~hwTrigEnable_q & (newChan != CH_OFF);
	wire lastTick = busy & conversionClock & (tick_q == convTicks - 6'h1);

	// Formatted sample and compare outcome
	wire [9:0] sample  = eightBit ? {2'b00, convInput[9:2]} : convInput;
	wire [9:0] cmpRef  = eightBit ? {2'b00, compareVal_q[7:0]} : compareVal_q;
	wire cmpTrue = cmpGreaterEq_q ? (sample >= cmpRef) : (sample < cmpRef);
	wire complete = lastTick & (~cmpEnable_q | cmpTrue);
	// Continuous mode re-arms itself; single returns to idle
	wire rearm = continuous_q & ~powerOff;

	// Converter sequencing
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			IDLE:    if (swStart || hwStart) state_d = CONVERT;
			CONVERT: if (lastTick && !rearm) state_d = IDLE;
		endcase
		if (wrSc && (hwTrigEnable_q || newChan == CH_OFF))
			state_d = IDLE;
		else if (swStart)
			state_d = CONVERT;
		if (stop2Mode)
			state_d = IDLE;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= IDLE;
			tick_q  <= 6'h0;
		end else begin
			state_q <= state_d;
			if (swStart || hwStart || lastTick || state_d == IDLE)
				tick_q <= 6'h0;
			else if (busy && conversionClock)
				tick_q <= tick_q + 6'h1;
		end
	end

	// Result and done flag; completion wins over a clearing read
	always_ff @(posedge clk) begin
		if (rst) begin
			result_q <= 10'h000;
			done_q   <= 1'b0;
		end else begin
			if (lastTick)
				result_q <= sample;
			if (complete)
				done_q <= 1'b1;
			else if (wrSc || rdResult)
				done_q <= 1'b0;
		end
	end
	assign convResult = result_q;
	assign convIrq    = done_q & irqEnable_q;

	// Real-time counter, prescaler and overflow pulse
	always_ff @(posedge clk) begin
		if (rst) begin
			prescale_q <= 16'h0;
			count_q    <= 8'h00;
			ovf_q      <= 1'b0;
		end else begin
			ovf_q <= overflow;
			if (wrCntCtl || wrCntMod) begin
				prescale_q <= 16'h0;
				count_q    <= 8'h00;
			end else if (cntRun && cntSrcTick && counterPrescaleField != 4'h0) begin
				prescale_q <= (prescale_q == prescaleMax) ? 16'h0 : prescale_q + 16'h1;
				if (cntTick)
					count_q <= overflow ? 8'h00 : count_q + 8'h01;
			end
		end
	end

	// Software-written registers
	always_ff @(posedge clk) begin
		if (rst) begin
			channelSelectField_q  <= CHAN_RESET;
			irqEnable_q           <= 1'b0;
			continuous_q          <= 1'b0;
			hwTrigEnable_q        <= 1'b0;
			cmpEnable_q           <= 1'b0;
			cmpGreaterEq_q        <= 1'b0;
			compareVal_q          <= 10'h000;
			convCfg_q             <= CFG_RESET;
			cntCtrl_q             <= CNTCTL_RESET;
			counterModuloReg_q    <= CNTMOD_RESET;
			bandgapBufferEnable_q <= 1'b0;
		end else begin
			if (wrSc) begin
				channelSelectField_q <= newChan;
				irqEnable_q          <= wdata[SC_IRQEN_BIT];
				continuous_q         <= wdata[SC_CONT_BIT];
			end
			if (wrCtrl) begin
				hwTrigEnable_q <= wdata[CT_HWTRG_BIT];
				cmpEnable_q    <= wdata[CT_CMPEN_BIT];
				cmpGreaterEq_q <= wdata[CT_CMPGE_BIT];
			end
			if (wrCmpLo)
				compareVal_q[7:0] <= wdata[7:0];
			if (wrCmpHi)
				compareVal_q[9:8] <= wdata[9:8];
			if (wrCfg)
				convCfg_q <= wdata[7:0];
			if (wrCntCtl)
				cntCtrl_q <= wdata[7:0];
			if (wrCntMod)
				counterModuloReg_q <= wdata[7:0];
			if (wrPwr)
				bandgapBufferEnable_q <= wdata[0];
		end
	end

	// Read mux, unused bits read zero
	logic [31:0] rdMux;
	always_comb begin
		rdMux = 32'h0;
		unique case (araddr)
			OFF_CONV_SC:   rdMux[7:0] = {done_q, irqEnable_q, continuous_q, channelSelectField_q};
			OFF_CONV_CTRL: rdMux[7:0] = {busy, hwTrigEnable_q, cmpEnable_q, cmpGreaterEq_q, 4'h0};
			OFF_RESULT:    rdMux[9:0] = result_q;
			OFF_COMPARE:   rdMux[9:0] = compareVal_q;
			OFF_CONV_CFG:  rdMux[7:0] = convCfg_q;
			OFF_CNT_CTRL:  rdMux[7:0] = {counterInterruptEnable, cntCtrl_q[6:0]};
			OFF_CNT_MOD:   rdMux[7:0] = counterModuloReg_q;
			OFF_PWR_CTRL:  rdMux[0]   = bandgapBufferEnable_q;
			OFF_CNT_VALUE: rdMux[7:0] = count_q;
			default:       rdMux      = 32'h0;
		endcase
	end

	// Bus responses: one cycle after acceptance, held until taken
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= 2'b00;
			rvalid_q <= 1'b0;
			rresp_q  <= 2'b00;
			rdata_q  <= 32'h0;
		end else begin
			if (wrFire) begin
				bvalid_q <= 1'b1;
				bresp_q  <= wrMapped ? 2'b00 : 2'b10;
			end else if (bready)
				bvalid_q <= 1'b0;
			if (rdFire) begin
				rvalid_q <= 1'b1;
				rresp_q  <= rdMapped ? 2'b00 : 2'b10;
				rdata_q  <= rdMux;
			end else if (rready)
				rvalid_q <= 1'b0;
		end
	end
endmodule : adc_channel_clock_trigger
`default_nettype wire

/* core/adc_ctl_pkg.sv */
// Shared constants for the converter control block: register map,
// field positions, reset values, channel codes and timing counts.
// Assumes a single 125 MHz bus clock and an AXI4-Lite register port.
package adc_ctl_pkg;

	// Register byte offsets
	localparam logic [5:0] OFF_CONV_SC   = 6'h00; // Channel, continuous, irq enable, done flag
	localparam logic [5:0] OFF_CONV_CTRL = 6'h04; // Trigger, compare, busy
	localparam logic [5:0] OFF_RESULT    = 6'h08; // Result, read clears done flag
	localparam logic [5:0] OFF_COMPARE   = 6'h0c; // Compare value
	localparam logic [5:0] OFF_CONV_CFG  = 6'h10; // Clock source, divider, mode, sample
	localparam logic [5:0] OFF_CNT_CTRL  = 6'h14; // Counter clock, prescale, irq enable
	localparam logic [5:0] OFF_CNT_MOD   = 6'h18; // Counter modulo
	localparam logic [5:0] OFF_PWR_CTRL  = 6'h1c; // Bandgap buffer enable
	localparam logic [5:0] OFF_CNT_VALUE = 6'h20; // Live counter value

	// Conversion status/control fields
	localparam int SC_DONE_BIT  = 7;
	localparam int SC_IRQEN_BIT = 6;
	localparam int SC_CONT_BIT  = 5;
	// Conversion control fields
	localparam int CT_BUSY_BIT  = 7;
	localparam int CT_HWTRG_BIT = 6;
	localparam int CT_CMPEN_BIT = 5;
	localparam int CT_CMPGE_BIT = 4;
	// Config fields
	localparam int CF_LONG_BIT  = 4;
	localparam int CF_MODE_BIT  = 2;
	localparam int CF_DIV_LSB   = 5;
	// Counter control fields
	localparam int CC_IRQEN_BIT = 7;
	localparam int CC_SRC_LSB   = 5;

	// Reset values
	localparam logic [4:0] CHAN_RESET  = 5'h1f;
	localparam logic [7:0] CFG_RESET   = 8'h00;
	localparam logic [7:0] CNTCTL_RESET = 8'h00;
	localparam logic [7:0] CNTMOD_RESET = 8'h00;

	// Channel codes
	localparam logic [4:0] CH_LAST_PIN  = 5'h0b;
	localparam logic [4:0] CH_GND_LAST  = 5'h14;
	localparam logic [4:0] CH_TEMP      = 5'h1a;
	localparam logic [4:0] CH_BANDGAP   = 5'h1b;
	localparam logic [4:0] CH_REF_HIGH  = 5'h1d;
	localparam logic [4:0] CH_REF_LOW   = 5'h1e;
	localparam logic [4:0] CH_OFF       = 5'h1f;
	localparam logic [9:0] RESERVED_VAL = 10'h155; // Undefined, do not rely on it

	// Conversion length in conversion clock ticks
	localparam logic [5:0] SHORT_TICKS = 6'h14;
	localparam logic [5:0] LONG_TICKS  = 6'h28;

	typedef enum logic [1:0] {SRC_BUS, SRC_BUS_HALF, SRC_ALT, SRC_LOCAL} conv_src_t;
	typedef enum logic [1:0] {CSRC_EXT, CSRC_INT, CSRC_LPO, CSRC_NONE} cnt_src_t;

endpackage : adc_ctl_pkg

/* core/adc_chan_route.sv */
// Channel decoder: routes the selected source onto the converter input.
// Assumes analog levels arrive already digitised as 10-bit samples.
`timescale 1ns/10ps
`default_nettype none
module adc_chan_route
	import adc_ctl_pkg::*;
(
	input  wire logic [4:0]       channelSelectField,
	input  wire logic [11:0][9:0] pinLevel,
	input  wire logic [9:0]       tempLevel,
	input  wire logic [9:0]       bandgapLevel,
	input  wire logic             bandgapBufferEnable,
	output logic      [9:0]       convInput,
	output logic                  powerOff
);
	// Decoded source classes
	wire isPin     = channelSelectField <= CH_LAST_PIN;
	wire isGround  = (channelSelectField > CH_LAST_PIN && channelSelectField <= CH_GND_LAST)
		|| channelSelectField == CH_REF_LOW;
	wire isTemp    = channelSelectField == CH_TEMP;
	wire isBandgap = channelSelectField == CH_BANDGAP;
	wire isHigh    = channelSelectField == CH_REF_HIGH;
	wire [3:0] pinIdx = channelSelectField[3:0];

	// Without the buffer the bandgap node floats, so the value is meaningless
	wire [9:0] bgValue = bandgapBufferEnable ? bandgapLevel : RESERVED_VAL;

	// Priority-free select, classes are disjoint
	assign convInput = isPin ? pinLevel[pinIdx] :
		isGround  ? 10'h000 :
		isHigh    ? 10'h3ff :
		isTemp    ? tempLevel :
		isBandgap ? bgValue : RESERVED_VAL;
	assign powerOff = channelSelectField == CH_OFF;
endmodule : adc_chan_route
`default_nettype wire

/* core/adc_conv_clock.sv */
// Conversion clock enable: picks one of four sources, then divides.
// Assumes local and alternate clocks arrive as one-cycle tick pulses.
`timescale 1ns/10ps
`default_nettype none
module adc_conv_clock
	import adc_ctl_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      rst,
	input  wire conv_src_t clockSource,
	input  wire logic [1:0] clockDivideField,
	input  wire logic      localAsyncConvClock,
	input  wire logic      alternateConvClock,
	input  wire logic      stopLowPower,
	input  wire logic      run,
	output logic           conversionClock
);
	logic       half_q;
	logic [2:0] div_q;
	logic       srcTick;

	// Source select; alternate clock is dead in either stop mode
	always_comb begin
		unique case (clockSource)
			SRC_BUS:      srcTick = 1'b1;
			SRC_BUS_HALF: srcTick = half_q;
			SRC_ALT:      srcTick = alternateConvClock & ~stopLowPower;
			SRC_LOCAL:    srcTick = localAsyncConvClock;
		endcase
	end

	// Divider counts source ticks, restarted while idle
	wire [2:0] divMax = 3'((4'h1 << clockDivideField) - 4'h1);
	assign conversionClock = run & srcTick & (div_q == divMax);

	// Bus half-rate toggle and the divide counter
	always_ff @(posedge clk) begin
		if (rst) begin
			half_q <= 1'b0;
			div_q  <= 3'h0;
		end else begin
			half_q <= ~half_q;
			if (!run)
				div_q <= 3'h0;
			else if (srcTick)
				div_q <= (div_q == divMax) ? 3'h0 : div_q + 3'h1;
		end
	end
endmodule : adc_conv_clock
`default_nettype wire

/* tb/adc_ctl_props.sv */
// Checker: bus handshakes and the trigger pulse at the top ports.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module adc_ctl_props
	import adc_ctl_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [5:0]  awaddr,
	input wire logic        awvalid,
	input wire logic        awready,
	input wire logic        wvalid,
	input wire logic        wready,
	input wire logic [1:0]  bresp,
	input wire logic        bvalid,
	input wire logic        bready,
	input wire logic        arvalid,
	input wire logic        arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0]  rresp,
	input wire logic        rvalid,
	input wire logic        rready,
	input wire logic        stop2Mode,
	input wire logic        convIrq,
	input wire logic        hwConversionTrigger
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Write channel: paired accept, answer one cycle later, held until taken
	chk_aw_pair: assert property (awready == wready) else $error("ready pair differs");
	chk_wr_answer: assert property (awvalid && wvalid && awready |=> bvalid)
		else $error("no write answer");
	chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write answer dropped");
	chk_wr_refuse: assert property (bvalid |-> !awready) else $error("write taken early");
	chk_bad_addr: assert property (awvalid && wvalid && awready && awaddr > OFF_CNT_VALUE
		|=> bresp == 2'b10) else $error("unmapped write okay");
	// Read channel mirrors the write side
	chk_rd_answer: assert property (arvalid && arready |=> rvalid) else $error("no read answer");
	chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
		else $error("read answer dropped");
	chk_rd_refuse: assert property (rvalid |-> !arready) else $error("read taken early");
	// One pulse per overflow; a frozen counter gives none
	chk_trig_pulse: assert property (hwConversionTrigger |=> !hwConversionTrigger)
		else $error("trigger too long");
	chk_stop2_quiet: assert property (stop2Mode [*2] |-> !hwConversionTrigger)
		else $error("trigger in stop2");

	cover property (hwConversionTrigger);
	cover property (convIrq);
	cover property (rvalid && rready);
endmodule : adc_ctl_props

bind adc_channel_clock_trigger adc_ctl_props u_props (.clk, .rst, .awaddr, .awvalid, .awready,
	.wvalid, .wready, .bresp, .bvalid, .bready, .arvalid, .arready, .rdata, .rresp, .rvalid,
	.rready, .stop2Mode, .convIrq, .hwConversionTrigger);
`default_nettype wire

/* tb/adc_far_side.sv */
// Far-side model: digitised analog samples and free-running clock ticks.
// Assumes clk is the bus clock; ticks are one-cycle pulses, except the ext and int reference ticks, which stay high two cycles as phase wraps.
`timescale 1ns/10ps
`default_nettype none
module adc_far_side #(
	parameter logic [9:0] PIN0  = 10'h003,
	parameter logic [9:0] PSTEP = 10'h025,
	parameter logic [9:0] TEMPV = 10'h2a5,
	parameter logic [9:0] BGV   = 10'h1c3
) (
	input  wire logic        clk,
	input  wire logic        rst,
	output logic [11:0][9:0] pinLevel,
	output logic [9:0]       tempLevel,
	output logic [9:0]       bandgapLevel,
	output logic             localAsyncConvClock,
	output logic             extReferenceClock,
	output logic             intReferenceClock,
	output logic             lowPowerOscTick
);
	logic [7:0] phase_q;

	// Pins sit on a ramp so a wrong route shows a wrong code
	always_comb begin
		for (int k = 0; k < 12; k++) pinLevel[k] = PIN0 + PSTEP * 10'(k);
	end
	assign tempLevel    = TEMPV;
	assign bandgapLevel = BGV;

	// Free-running phase; sources run at unrelated rates
	always_ff @(posedge clk) begin
		if (rst) phase_q <= 8'h00;
		else phase_q <= phase_q + 8'h01;
	end
	// Reference ticks never stop in wait, so they stay usable there
	assign localAsyncConvClock = phase_q[0];
	assign extReferenceClock   = (phase_q % 8'h03) == 8'h00;
	assign intReferenceClock   = (phase_q % 8'h05) == 8'h00;
	assign lowPowerOscTick     = phase_q[2:0] == 3'h0;
endmodule : adc_far_side
`default_nettype wire

/* tb/adc_channel_clock_trigger_test.sv */
// Testbench: registers over AXI4-Lite, conversions checked by value.
// Assumes the far-side model supplies samples and clock ticks.
`timescale 1ns/10ps
`default_nettype none
module adc_channel_clock_trigger_test;
	import adc_ctl_pkg::*;
	localparam logic [9:0] PIN0 = 10'h003, PSTEP = 10'h025, TEMPV = 10'h2a5, BGV = 10'h1c3;
	logic             clk, rst, awvalid, wvalid, bready, arvalid, rready, ok;
	logic             waitMode, stop2Mode, stop3Mode, awready, wready, bvalid, arready, rvalid;
	logic             convIrq, hwConversionTrigger, localAsyncConvClock, lowPowerOscTick;
	logic             extReferenceClock, intReferenceClock;
	logic [5:0]       awaddr, araddr;
	logic [31:0]      wdata, rdata, rdv;
	logic [3:0]       wstrb;
	logic [1:0]       bresp, rresp, rs;
	logic [9:0]       convResult, tempLevel, bandgapLevel;
	logic [11:0][9:0] pinLevel;
	int               errorCnt, nTests;

	adc_channel_clock_trigger u_dut (.clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
		.rvalid, .rready, .pinLevel, .tempLevel, .bandgapLevel, .localAsyncConvClock,
		.extReferenceClock, .intReferenceClock, .lowPowerOscTick, .waitMode, .stop2Mode,
		.stop3Mode, .convIrq, .hwConversionTrigger, .convResult);
	adc_far_side #(.PIN0(PIN0), .PSTEP(PSTEP), .TEMPV(TEMPV), .BGV(BGV)) u_far (.clk, .rst,
		.pinLevel, .tempLevel, .bandgapLevel, .localAsyncConvClock, .extReferenceClock,
		.intReferenceClock, .lowPowerOscTick);

	task testDone;
		$display("errors %0d compares %0d", errorCnt, nTests);
		if (errorCnt == 0 && nTests > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : testDone
	task cmp(input logic [31:0] g, input logic [31:0] e);
		nTests++;
		if (g !== e) begin
			errorCnt++;
			$display("ERROR %0t got %h want %h", $time, g, e);
		end
	endtask : cmp
	// A bound that runs out ends the run
	task tmo(input int n);
		if (n >= 200) begin
			errorCnt++;
			$display("ERROR %0t wait timed out", $time);
			testDone();
		end
	endtask : tmo
	// Ready for the answer is raised late so the held answer is seen
	task wr(input logic [5:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (awready !== 1'b1 && n < 200);
		tmo(n);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do begin @(posedge clk); n++; end while (bvalid !== 1'b1 && n < 200);
		tmo(n);
		bready <= 1'b1;
		@(posedge clk);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr
	task rd(input logic [5:0] a);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		n = 0;
		do begin @(posedge clk); n++; end while (arready !== 1'b1 && n < 200);
		tmo(n);
		arvalid <= 1'b0;
		do begin @(posedge clk); n++; end while (rvalid !== 1'b1 && n < 200);
		tmo(n);
		rready <= 1'b1;
		@(posedge clk);
		rdv = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	// Polls the done flag for at most lim reads
	task poll(input int lim);
		int n;
		n = 0;
		ok = 1'b0;
		while (!ok && n < lim) begin
			rd(OFF_CONV_SC);
			ok = rdv[SC_DONE_BIT];
			n++;
		end
	endtask : poll
	task conv(input logic [7:0] sc, input int lim);
		wr(OFF_CONV_SC, {24'h0, sc});
		poll(lim);
	endtask : conv
	function automatic logic [9:0] expVal(input logic [4:0] c);
		if (c <= CH_LAST_PIN) return PIN0 + PSTEP * {5'h0, c};
		if (c == CH_TEMP) return TEMPV;
		if (c == CH_BANDGAP) return BGV;
		if (c == CH_REF_HIGH) return 10'h3ff;
		return 10'h000;
	endfunction : expVal

	// Descending codes convert the bandgap before the sensor
	task tChan;
		wr(OFF_PWR_CTRL, 32'h1);
		wr(OFF_CONV_CFG, 32'h14);
		for (int c = 30; c >= 0; c--) begin
			conv({3'h2, 5'(c)}, 200);
			cmp(ok, 1);
			cmp(convIrq, 1);
			rd(OFF_RESULT);
			cmp(convIrq, 0);
			if (!(c inside {[21:25], 28})) cmp(rdv, {22'h0, expVal(5'(c))});
			if (!(c inside {[21:25], 28})) cmp(convResult, {22'h0, expVal(5'(c))});
		end
		wr(OFF_CONV_CFG, 32'h0);
		conv(8'h05, 200);
		rd(OFF_RESULT);
		cmp(rdv, {22'h0, expVal(5'h05) >> 2});
		$display("channel map done");
	endtask : tChan
	task tClk;
		waitMode <= 1'b1;
		for (int s = 0; s < 4; s++) begin
			wr(OFF_CONV_CFG, 32'h4 | 32'(s) | 32'(s << 5));
			conv(8'h03, 200);
			cmp(ok, 1);
			rd(OFF_RESULT);
			cmp(rdv, {22'h0, expVal(5'h03)});
		end
		waitMode <= 1'b0;
		stop3Mode <= 1'b1;
		wr(OFF_CONV_CFG, 32'h6);
		conv(8'h03, 30);
		cmp(ok, 0);
		stop3Mode <= 1'b0;
		wr(OFF_CONV_CFG, 32'h4);
		$display("clock sources done");
	endtask : tClk
	// Counter interrupt enable set only for the middle source
	task tTrig;
		int n;
		stop3Mode <= 1'b1;
		wr(OFF_CONV_CTRL, 32'h40);
		wr(OFF_CNT_MOD, 32'h2);
		for (int s = 0; s < 3; s++) begin
			wr(OFF_CNT_CTRL, 32'(s << 5) | (32'(s == 1) << 7) | 32'h1);
			n = 0;
			do begin @(posedge clk); n++; end while (hwConversionTrigger !== 1'b1 && n < 200);
			tmo(n);
			conv(8'h04, 100);
			cmp(ok, 1);
			rd(OFF_RESULT);
			cmp(rdv, {22'h0, expVal(5'h04)});
		end
		stop2Mode <= 1'b1;
		@(posedge clk); // A pulse launched before stop2 took hold is legal
		n = 0;
		repeat (100) begin @(posedge clk); n += int'(hwConversionTrigger === 1'b1); end
		cmp(n, 0);
		stop2Mode <= 1'b0;
		stop3Mode <= 1'b0;
		wr(OFF_CONV_CTRL, 32'h0);
		$display("trigger done");
	endtask : tTrig
	task tCmp;
		logic [9:0] v;
		v = expVal(5'h05);
		wr(OFF_CONV_CTRL, 32'h20);
		wr(OFF_COMPARE, {22'h0, v + 10'h1});
		conv(8'h05, 200);
		cmp(ok, 1);
		wr(OFF_COMPARE, {22'h0, v});
		conv(8'h05, 30);
		cmp(ok, 0);
		wr(OFF_CONV_CTRL, 32'h30);
		conv(8'h05, 200);
		cmp(ok, 1);
		wr(OFF_CONV_CTRL, 32'h0);
		$display("compare done");
	endtask : tCmp
	// Restart mid-conversion, continuous run, then channel off
	task tAbort;
		wr(OFF_CONV_SC, 32'h01);
		repeat (5) @(posedge clk);
		conv(8'h02, 200);
		rd(OFF_RESULT);
		cmp(rdv, {22'h0, expVal(5'h02)});
		rd(OFF_CONV_CTRL);
		cmp(rdv[CT_BUSY_BIT], 0);
		conv(8'h26, 200);
		rd(OFF_RESULT);
		poll(60);
		cmp(ok, 1);
		rd(OFF_CONV_CTRL);
		cmp(rdv[CT_BUSY_BIT], 1);
		wr(OFF_CONV_SC, 32'h3f);
		rd(OFF_CONV_CTRL);
		cmp(rdv[CT_BUSY_BIT], 0);
		conv(8'h3f, 30);
		cmp(ok, 0);
		rd(6'h24);
		cmp(rs, 2'b10);
		wr(6'h24, 32'h0);
		cmp(rs, 2'b10);
		$display("abort and off done");
	endtask : tAbort

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial begin
		{rst, wstrb} = 5'h1f;
		{awvalid, wvalid, bready, arvalid, rready, waitMode, stop2Mode, stop3Mode} = 8'h00;
		{awaddr, araddr, wdata} = 44'h0;
		errorCnt = 0;
		nTests = 0;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFF_CONV_SC);
		cmp(rdv, {27'h0, CHAN_RESET});
		tChan();
		tClk();
		tTrig();
		tCmp();
		tAbort();
		testDone();
	end
endmodule : adc_channel_clock_trigger_test
`default_nettype wire
